// ---- csfm_pkg.sv ----
// Behaviour
// RQ1: status register resets to 0x04 at power-on.
// RQ2: bit 0 follows the card presence input.
// RQ3: bit 1 latches on any presence edge, interrupts, clears on status read.
// RQ4: bit 2 mirrors the card I/O line level.
// RQ5: bit 3 latches on any supply fault, interrupts, clears on status read.
// RQ6: bit 4 latches on over-current or over-temperature in session, interrupts, clears on read.
// RQ7: bit 5 sets when no answer within 40000 card clocks; clears at next session.
// RQ8: bit 6 sets when answer starts before 400 card clocks; clears at next session.
// RQ9: bit 7 is one while the card session is powered.
// RQ10: master reads with START plus address, read bit one; device acknowledges with zero.
// RQ11: after the address acknowledge the device shifts out all eight status bits.
// RQ12: master answers the data byte with a one, then sends STOP.
// RQ13: any of the three supply supervisor faults forces card deactivation.
// RQ14: regulator input below card supply counts as fault and deactivates.
// RQ15: digital supply supervisor resets sequencer at power-on, deactivates on fault.
// RQ16: over-temperature deactivates the card, sets bit 4 and interrupts.
// RQ17: control bit 2 selects card supply, one for 3 V, zero for 5 V.
// RQ18: active-low interrupt returns high after the host reads status.
// RQ19: deactivation drops reset, clock, I/O, supply in order, each after an interval.
// RQ20: status is captured at data byte start; events then are not lost.
// RQ21: presence input is synchronised before edge detection, one event per change.
package csfm_pkg;
  localparam int CORE_CLK_MHZ   = 40;
  localparam int DEACT_STEP_NS  = 2000;
  localparam int DEACT_STEP_CYC = (DEACT_STEP_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int MUTE_CARD_CYC  = 40000;
  localparam int EARLY_CARD_CYC = 400;

  localparam int ST_PRESENT = 0;
  localparam int ST_PCHG    = 1;
  localparam int ST_IO      = 2;
  localparam int ST_SUP     = 3;
  localparam int ST_PROTECT = 4;
  localparam int ST_MUTE    = 5;
  localparam int ST_EARLY   = 6;
  localparam int ST_ACT     = 7;
  localparam logic [7:0] STAT_RST = 8'h04;

  localparam int CTRL_START = 0;
  localparam int CTRL_VSEL  = 2;

  localparam logic [6:0] I2C_ADDR_BASE = 7'h20;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  typedef struct packed {
    logic vdd;
    logic vreg;
    logic vcc;
    logic vreg_low;
    logic ovc;
    logic ovt;
  } csfm_faults_t;

  typedef struct packed {
    logic         scl;
    logic         sda;
    logic         present;
    logic         io;
    csfm_faults_t flt;
    logic [2:0]   sad;
  } csfm_pins_t;

  typedef enum logic [2:0] {SEQ_OFF, SEQ_ON, SEQ_D_RST, SEQ_D_CLK, SEQ_D_IO, SEQ_D_VCC} csfm_seq_e;
  typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_DATA, I2C_MACK} csfm_i2c_e;

  typedef struct packed {
    csfm_pins_t  s1;
    csfm_pins_t  s2;
    logic        scl_d;
    logic        sda_d;
    logic        present_d;
    logic        mute_s1;
    logic        mute_s2;
    logic        mute_d;
    logic        early_s1;
    logic        early_s2;
    logic        early_d;
    csfm_seq_e   seq;
    logic [15:0] step_cnt;
    logic [7:0]  stat;
    logic        irq_pend;
    logic        int_n;
    logic        vsel;
    logic        supply_on;
    logic        clk_en;
    logic        io_en;
    logic        rst_rel;
    logic        atr_win;
    csfm_i2c_e   i2c;
    logic [3:0]  bit_cnt;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic        sda_oe;
    logic        sda_out;
  } csfm_core_st_t;

  typedef struct packed {
    logic        rst_s1;
    logic        rst_s2;
    logic        win_s1;
    logic        win_s2;
    logic        win_d;
    logic        io_s1;
    logic        io_s2;
    logic        io_d;
    logic [15:0] cnt;
    logic        done;
    logic        mute;
    logic        early;
  } csfm_card_st_t;
endpackage

// ---- csfm_top.sv ----
`timescale 1ns/1ps
module csfm_top #(
  parameter int MUTE_CYC  = csfm_pkg::MUTE_CARD_CYC,
  parameter int EARLY_CYC = csfm_pkg::EARLY_CARD_CYC,
  parameter int DEACT_CYC = csfm_pkg::DEACT_STEP_CYC
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_card_clk,
  input  wire logic                 i_scl,
  input  wire logic                 i_sda,
  output logic                      o_sda_o,
  output logic                      o_sda_oe,
  input  wire logic [2:0]           i_sad,
  input  wire logic [7:0]           i_control,
  input  wire logic                 i_card_present,
  input  wire logic                 i_card_io,
  input  wire csfm_pkg::csfm_faults_t i_faults,
  output logic                      o_int_n,
  output logic [7:0]                o_card_status,
  output logic                      o_card_voltage_select,
  output logic                      o_card_supply_on,
  output logic                      o_card_clk_en,
  output logic                      o_card_io_en,
  output logic                      o_card_rst_rel
);

  // ****************
  // parameter checks
  // ****************
  if (EARLY_CYC < 1 || EARLY_CYC >= MUTE_CYC || MUTE_CYC > 65535) begin : g_bad_atr
    $error("atr cycle limits out of range");
  end
  if (DEACT_CYC < 1 || DEACT_CYC > 65535) begin : g_bad_deact
    $error("deactivation step count out of range");
  end

  localparam logic [15:0] MUTE_LIM  = 16'(MUTE_CYC - 1);
  localparam logic [15:0] EARLY_LIM = 16'(EARLY_CYC);
  localparam logic [15:0] STEP_LIM  = 16'(DEACT_CYC - 1);

  function automatic logic rose(input logic prev, input logic cur);
    rose = !prev && cur;
  endfunction

  function automatic logic fell(input logic prev, input logic cur);
    fell = prev && !cur;
  endfunction

  // ****************
  // core domain
  // ****************
  csfm_pkg::csfm_core_st_t r;
  csfm_pkg::csfm_core_st_t next_r;
  csfm_pkg::csfm_card_st_t c;
  csfm_pkg::csfm_card_st_t next_c;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic rd_clr;
  logic vfault;
  logic pchg;
  logic in_session;
  logic begin_sess;
  logic kill;
  logic mute_edge;
  logic early_edge;
  logic step_done;
  logic [7:0] lat;

  always_comb begin
    next_r = r;
    next_r.s1 = '{scl: i_scl, sda: i_sda, present: i_card_present, io: i_card_io, flt: i_faults, sad: i_sad};
    next_r.s2 = r.s1;
    next_r.scl_d = r.s2.scl;
    next_r.sda_d = r.s2.sda;
    next_r.present_d = r.s2.present;
    next_r.mute_s1 = c.mute;
    next_r.mute_s2 = r.mute_s1;
    next_r.mute_d = r.mute_s2;
    next_r.early_s1 = c.early;
    next_r.early_s2 = r.early_s1;
    next_r.early_d = r.early_s2;

    scl_rise = rose(r.scl_d, r.s2.scl);
    scl_fall = fell(r.scl_d, r.s2.scl);
    bus_start = r.s2.scl && r.scl_d && fell(r.sda_d, r.s2.sda);
    bus_stop = r.s2.scl && r.scl_d && rose(r.sda_d, r.s2.sda);
    rd_clr = 1'b0;

    // i2c slave: only reads of the status byte are answered
    if (bus_start) begin
      next_r.i2c = csfm_pkg::I2C_ADDR;
      next_r.bit_cnt = '0;
      next_r.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_r.i2c = csfm_pkg::I2C_IDLE;
      next_r.sda_oe = 1'b0;
    end else begin
      case (r.i2c)
        csfm_pkg::I2C_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        csfm_pkg::I2C_ADDR: begin
          if (scl_rise) begin
            next_r.rx = {r.rx[6:0], r.s2.sda};
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall && r.bit_cnt == csfm_pkg::I2C_BYTE_BITS) begin
            if (r.rx[7:1] == (csfm_pkg::I2C_ADDR_BASE | {4'h0, r.s2.sad}) && r.rx[0]) begin
              next_r.i2c = csfm_pkg::I2C_ACK_A;
              next_r.sda_oe = 1'b1; // RQ10
            end else begin
              next_r.i2c = csfm_pkg::I2C_IDLE;
            end
          end
        end
        csfm_pkg::I2C_ACK_A: begin
          if (scl_fall) begin
            // snapshot and clear in one cycle; a set in this cycle lands after the clear
            rd_clr = 1'b1; // RQ20
            next_r.tx = r.stat; // RQ11
            next_r.sda_oe = !r.stat[7];
            next_r.bit_cnt = '0;
            next_r.i2c = csfm_pkg::I2C_DATA;
          end
        end
        csfm_pkg::I2C_DATA: begin
          if (scl_rise) begin
            next_r.bit_cnt = r.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (r.bit_cnt == csfm_pkg::I2C_BYTE_BITS) begin
              next_r.sda_oe = 1'b0;
              next_r.i2c = csfm_pkg::I2C_MACK;
            end else begin
              next_r.tx = {r.tx[6:0], 1'b0}; // RQ11
              next_r.sda_oe = !r.tx[6];
            end
          end
        end
        csfm_pkg::I2C_MACK: begin
          // a one ends the read; a zero asks for the status byte again
          if (scl_rise) begin
            next_r.i2c = r.s2.sda ? csfm_pkg::I2C_IDLE : csfm_pkg::I2C_ACK_A; // RQ12
          end
        end
        default: begin
          next_r.i2c = csfm_pkg::I2C_IDLE;
          next_r.sda_oe = 1'b0;
        end
      endcase
    end

    // ****************
    // supervision and sequencer
    // ****************
    vfault = r.s2.flt.vdd || r.s2.flt.vreg || r.s2.flt.vcc || r.s2.flt.vreg_low; // RQ14
    pchg = r.s2.present ^ r.present_d; // RQ21
    in_session = r.seq != csfm_pkg::SEQ_OFF;
    mute_edge = rose(r.mute_d, r.mute_s2);
    early_edge = rose(r.early_d, r.early_s2);
    step_done = r.step_cnt == STEP_LIM;
    begin_sess = 1'b0;
    kill = !i_control[csfm_pkg::CTRL_START] || vfault || r.s2.flt.ovt || r.s2.flt.ovc || !r.s2.present;

    case (r.seq)
      csfm_pkg::SEQ_OFF: begin
        // the supply choice is only taken while the card is unpowered
        next_r.vsel = i_control[csfm_pkg::CTRL_VSEL]; // RQ17
        if (!kill) begin
          begin_sess = 1'b1;
          next_r.seq = csfm_pkg::SEQ_ON;
          next_r.supply_on = 1'b1;
          next_r.clk_en = 1'b1;
          next_r.io_en = 1'b1;
          next_r.rst_rel = 1'b1;
          next_r.atr_win = 1'b1;
        end
      end
      csfm_pkg::SEQ_ON: begin
        if (kill) begin
          next_r.seq = csfm_pkg::SEQ_D_RST; // RQ13 RQ15 RQ16
          next_r.step_cnt = '0;
          next_r.atr_win = 1'b0;
        end
      end
      csfm_pkg::SEQ_D_RST: begin
        next_r.step_cnt = r.step_cnt + 16'h0001;
        if (step_done) begin
          next_r.rst_rel = 1'b0; // RQ19
          next_r.step_cnt = '0;
          next_r.seq = csfm_pkg::SEQ_D_CLK;
        end
      end
      csfm_pkg::SEQ_D_CLK: begin
        next_r.step_cnt = r.step_cnt + 16'h0001;
        if (step_done) begin
          next_r.clk_en = 1'b0; // RQ19
          next_r.step_cnt = '0;
          next_r.seq = csfm_pkg::SEQ_D_IO;
        end
      end
      csfm_pkg::SEQ_D_IO: begin
        next_r.step_cnt = r.step_cnt + 16'h0001;
        if (step_done) begin
          next_r.io_en = 1'b0; // RQ19
          next_r.step_cnt = '0;
          next_r.seq = csfm_pkg::SEQ_D_VCC;
        end
      end
      csfm_pkg::SEQ_D_VCC: begin
        next_r.step_cnt = r.step_cnt + 16'h0001;
        if (step_done) begin
          next_r.supply_on = 1'b0; // RQ19
          next_r.step_cnt = '0;
          next_r.seq = csfm_pkg::SEQ_OFF;
        end
      end
      default: begin
        next_r.seq = csfm_pkg::SEQ_OFF;
      end
    endcase

    // ****************
    // status register
    // ****************
    // clears first, sets after, so a set in the clearing cycle survives
    lat = r.stat;
    if (rd_clr) begin
      lat[csfm_pkg::ST_PCHG] = 1'b0; // RQ3
      lat[csfm_pkg::ST_SUP] = 1'b0; // RQ5
      lat[csfm_pkg::ST_PROTECT] = 1'b0; // RQ6
    end
    if (begin_sess) begin
      lat[csfm_pkg::ST_MUTE] = 1'b0; // RQ7
      lat[csfm_pkg::ST_EARLY] = 1'b0; // RQ8
    end
    lat[csfm_pkg::ST_PRESENT] = r.s2.present; // RQ2
    lat[csfm_pkg::ST_IO] = r.s2.io; // RQ4
    lat[csfm_pkg::ST_ACT] = next_r.supply_on; // RQ9
    lat[csfm_pkg::ST_PCHG] = lat[csfm_pkg::ST_PCHG] | pchg; // RQ3
    lat[csfm_pkg::ST_SUP] = lat[csfm_pkg::ST_SUP] | vfault; // RQ5
    lat[csfm_pkg::ST_PROTECT] = lat[csfm_pkg::ST_PROTECT] | r.s2.flt.ovt | (r.s2.flt.ovc & in_session); // RQ6 RQ16
    lat[csfm_pkg::ST_MUTE] = lat[csfm_pkg::ST_MUTE] | mute_edge; // RQ7
    lat[csfm_pkg::ST_EARLY] = lat[csfm_pkg::ST_EARLY] | early_edge; // RQ8
    next_r.stat = lat;

    next_r.irq_pend = (r.irq_pend && !rd_clr) || pchg || vfault || r.s2.flt.ovt
                      || (r.s2.flt.ovc && in_session) || mute_edge || early_edge;
    // supply faults hold the line low by level; latched events until a read
    next_r.int_n = !(next_r.irq_pend || vfault); // RQ18
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      r <= '0;
      r.stat <= csfm_pkg::STAT_RST; // RQ1
      r.int_n <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      // sync stages rest at idle line levels, so no false bus edge or io drop follows reset
      r.s1.scl <= 1'b1;
      r.s2.scl <= 1'b1;
      r.s1.sda <= 1'b1;
      r.s2.sda <= 1'b1;
      r.s1.io <= 1'b1;
      r.s2.io <= 1'b1;
      r.seq <= csfm_pkg::SEQ_OFF; // RQ15
      r.i2c <= csfm_pkg::I2C_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ****************
  // card clock domain
  // ****************
  // the card clock may stop after deactivation; results are held as levels and
  // only reset by the next window opening, which the core reads by edge
  always_comb begin
    next_c = c;
    next_c.rst_s1 = 1'b0;
    next_c.rst_s2 = c.rst_s1;
    next_c.win_s1 = r.atr_win;
    next_c.win_s2 = c.win_s1;
    next_c.win_d = c.win_s2;
    next_c.io_s1 = i_card_io;
    next_c.io_s2 = c.io_s1;
    next_c.io_d = c.io_s2;
    if (rose(c.win_d, c.win_s2)) begin
      next_c.cnt = '0;
      next_c.done = 1'b0;
      next_c.mute = 1'b0;
      next_c.early = 1'b0;
    end else if (c.win_s2 && !c.done) begin
      if (fell(c.io_d, c.io_s2)) begin
        next_c.done = 1'b1;
        next_c.early = c.cnt < EARLY_LIM; // RQ8
      end else if (c.cnt == MUTE_LIM) begin
        next_c.done = 1'b1;
        next_c.mute = 1'b1; // RQ7
      end else begin
        next_c.cnt = c.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_card_clk or posedge i_rst) begin
    if (i_rst) begin
      c <= '0;
      c.rst_s1 <= 1'b1;
      c.rst_s2 <= 1'b1;
      c.io_d <= 1'b1;
    end else if (c.rst_s2) begin
      c <= next_c;
      c.cnt <= '0;
      c.done <= 1'b1;
      c.mute <= 1'b0;
      c.early <= 1'b0;
    end else begin
      c <= next_c;
    end
  end

  assign o_sda_o = r.sda_out;
  assign o_sda_oe = r.sda_oe;
  assign o_int_n = r.int_n;
  assign o_card_status = r.stat;
  assign o_card_voltage_select = r.vsel;
  assign o_card_supply_on = r.supply_on;
  assign o_card_clk_en = r.clk_en;
  assign o_card_io_en = r.io_en;
  assign o_card_rst_rel = r.rst_rel;

endmodule

// ---- csfm_top_sva.sv ----
`timescale 1ns/1ps
// ****************************
// status and sequencer checks
// ****************************
module csfm_top_sva #(
  parameter int MUTE_CYC  = 40000,
  parameter int EARLY_CYC = 400,
  parameter int DEACT_CYC = 80
) (
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire logic                   i_card_present,
  input wire logic                   i_card_io,
  input wire csfm_pkg::csfm_faults_t i_faults,
  input wire logic                   o_sda_oe,
  input wire logic                   o_int_n,
  input wire logic [7:0]             o_card_status,
  input wire logic                   o_card_voltage_select,
  input wire logic                   o_card_supply_on,
  input wire logic                   o_card_clk_en,
  input wire logic                   o_card_io_en,
  input wire logic                   o_card_rst_rel
);
  // whole deactivation plus input sync, with slack
  localparam int DW = 4 * DEACT_CYC + 8;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence s_clk_held;
    o_card_clk_en [*3];
  endsequence
  sequence s_clk_off_first;
    !o_card_clk_en && o_card_io_en && o_card_supply_on;
  endsequence
  chk_reset_value: assert property (disable iff (1'b0) i_rst |=> o_card_status == 8'h04 && o_int_n && !o_sda_oe)
    else $error("status not at reset value");
  chk_present_follow: assert property ($rose(i_card_present) |-> ##[1:4] o_card_status[0])
    else $error("presence bit late");
  chk_present_event: assert property ($changed(i_card_present) |-> ##[1:5] (o_card_status[1] && !o_int_n))
    else $error("presence change not latched");
  chk_io_mirror: assert property ($changed(i_card_io) |-> ##[1:4] o_card_status[2] == i_card_io)
    else $error("io bit wrong");
  chk_supply_fault: assert property (|i_faults[5:2] |-> ##[1:5] (o_card_status[3] && !o_int_n))
    else $error("supply fault not latched");
  chk_fault_deact: assert property (o_card_supply_on && |i_faults |-> ##[1:DW] !o_card_supply_on)
    else $error("fault did not deactivate");
  chk_deact_order: assert property ($fell(o_card_rst_rel) |-> s_clk_held ##[1:DW] s_clk_off_first)
    else $error("clock stop out of order");
  chk_supply_last: assert property ($fell(o_card_supply_on) |-> !o_card_rst_rel && $past(o_card_io_en) == 1'b0)
    else $error("supply cut too early");
  chk_active_bit: assert property ($changed(o_card_supply_on) |-> ##[0:2] o_card_status[7] == o_card_supply_on)
    else $error("active bit wrong");
  chk_vsel_frozen: assert property (o_card_supply_on && $past(o_card_supply_on) |-> $stable(o_card_voltage_select))
    else $error("voltage changed in session");
endmodule

bind csfm_top csfm_top_sva #(
  .MUTE_CYC(MUTE_CYC), .EARLY_CYC(EARLY_CYC), .DEACT_CYC(DEACT_CYC)
) i_csfm_top_sva (
  .i_core_clk, .i_rst, .i_card_present, .i_card_io, .i_faults, .o_sda_oe, .o_int_n, .o_card_status,
  .o_card_voltage_select, .o_card_supply_on, .o_card_clk_en, .o_card_io_en, .o_card_rst_rel
);

// ---- csfm_i2c_host.sv ----
`timescale 1ns/1ps
module csfm_i2c_host #(
  parameter int Q = 4
) (
  input  wire logic i_core_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output logic      o_sda
);
  logic drv;
  // open drain: a released line floats high on the pull-up
  assign o_sda = drv & ~i_sda_oe;
  initial begin
    o_scl = 1'b1;
    drv = 1'b1;
  end
  task automatic q(input int n);
    repeat (n * Q) @(posedge i_core_clk);
  endtask
  task automatic bit_slot(input logic b, output logic s);
    drv <= b;
    q(1);
    o_scl <= 1'b1;
    q(2);
    s = o_sda;
    o_scl <= 1'b0;
    q(1);
  endtask
  // a zero master acknowledge asks for one more snapshot byte, returned in the low half
  task automatic read(input logic [6:0] a, input logic mack, output logic [15:0] d, output logic ack);
    logic [7:0] sh;
    logic       s;
    sh = {a, 1'b1};
    d = '0;
    drv <= 1'b0;
    q(2);
    o_scl <= 1'b0;
    q(1);
    for (int k = 7; k >= 0; k--) begin
      bit_slot(sh[k], s);
    end
    bit_slot(1'b1, ack);
    for (int k = 15; k >= 8; k--) begin
      bit_slot(1'b1, d[k]);
    end
    bit_slot(mack, s);
    if (!mack) begin
      for (int k = 7; k >= 0; k--) begin
        bit_slot(1'b1, d[k]);
      end
      bit_slot(1'b1, s);
    end
    drv <= 1'b0;
    q(1);
    o_scl <= 1'b1;
    q(1);
    drv <= 1'b1;
    q(4);
  endtask
endmodule

// ---- test_card_status_fault_monitor.sv ----
`timescale 1ns/1ps
module test_card_status_fault_monitor;
  localparam logic [6:0] ADDR = csfm_pkg::I2C_ADDR_BASE | 7'h05;
  typedef struct packed {
    logic                   present;
    logic                   io;
    csfm_pkg::csfm_faults_t flt;
    logic [7:0]             stat;
    logic                   int_n;
  } csfm_row_t;
  logic                   clk, cclk, rst, present, io, scl, sda, sda_o, sda_oe, int_n, vsel;
  logic [7:0]             ctl, st;
  wire  [3:0]             en;
  csfm_pkg::csfm_faults_t flt;
  csfm_row_t              rows [9];
  int                     n_mismatch = 0;
  int                     cmp_count = 0;

  csfm_top #(.MUTE_CYC(100), .EARLY_CYC(10), .DEACT_CYC(4)) i_csfm_top (
    .i_core_clk(clk), .i_rst(rst), .i_card_clk(cclk), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_sad(3'h5), .i_control(ctl), .i_card_present(present), .i_card_io(io),
    .i_faults(flt), .o_int_n(int_n), .o_card_status(st), .o_card_voltage_select(vsel),
    .o_card_supply_on(en[0]), .o_card_clk_en(en[2]), .o_card_io_en(en[1]), .o_card_rst_rel(en[3])
  );
  csfm_i2c_host i_csfm_i2c_host (.i_core_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // card clock free running, phase unrelated to the core clock
  initial begin
    cclk = 1'b0;
    #3;
    forever #6 cclk = ~cclk;
  end
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  // ****************
  // helpers
  // ****************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic exp_ack, input logic mack);
    logic [15:0] d;
    logic        k;
    i_csfm_i2c_host.read(a, mack, d, k);
    cmp1(k, exp_ack);
    cmp1(sda_o, 1'b0);
    if (!exp_ack) begin
      cmp8(d[15:8], exp);
    end
    if (!exp_ack && !mack) begin
      cmp8(d[7:0], exp & 8'hE5);
    end
  endtask
  task automatic till(input int k, input logic v);
    int n;
    n = 0;
    while (en[k] !== v && n < 100) begin
      @(posedge clk);
      n++;
    end
    cmp1(en[k], v);
  endtask
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************
  // stimulus
  // ****************
  initial begin
    rst = 1'b1;
    present = 1'b0;
    io = 1'b1;
    ctl = 8'h00;
    flt = '0;
    rows = '{'{1, 1, 6'h00, 8'h07, 0}, '{1, 0, 6'h00, 8'h01, 1}, '{1, 1, 6'h01, 8'h15, 0},
             '{1, 1, 6'h20, 8'h0D, 0}, '{1, 1, 6'h10, 8'h0D, 0}, '{1, 1, 6'h08, 8'h0D, 0},
             '{1, 1, 6'h04, 8'h0D, 0}, '{1, 1, 6'h02, 8'h05, 1}, '{0, 1, 6'h00, 8'h06, 0}};
    cyc(8);
    cmp8(st, 8'h04);
    rst <= 1'b0;
    cyc(8);
    cmp8(st, 8'h04);
    foreach (rows[r]) begin
      present <= rows[r].present;
      io <= rows[r].io;
      flt <= rows[r].flt;
      cyc(8);
      cmp8(st, rows[r].stat);
      cmp1(int_n, rows[r].int_n);
      flt <= '0;
      cyc(8);
      rd(ADDR, rows[r].stat, 1'b0, 1'b1);
      cyc(8);
      cmp8(st, rows[r].stat & 8'hE5);
      cmp1(int_n, 1'b1);
    end
    present <= 1'b1;
    ctl <= 8'h05;
    till(0, 1'b1);
    cyc(4);
    cmp1(vsel, 1'b1);
    cmp1(st[7], 1'b1);
    cyc(80);
    cmp8(st & 8'hE0, 8'hA0);
    flt <= 6'h02;
    for (int k = 3; k > 0; k--) begin
      till(k, 1'b0);
      cmp1(en[k - 1], 1'b1);
    end
    till(0, 1'b0);
    cyc(4);
    cmp8(st & 8'h90, 8'h10);
    flt <= '0;
    ctl <= 8'h00;
    cyc(8);
    rd(ADDR, 8'h37, 1'b0, 1'b0);
    cyc(8);
    cmp8(st, 8'h25);
    ctl <= 8'h01;
    till(0, 1'b1);
    cyc(2);
    io <= 1'b0;
    cyc(24);
    cmp8(st & 8'hE0, 8'hC0);
    cmp1(vsel, 1'b0);
    rd(ADDR ^ 7'h01, 8'h00, 1'b1, 1'b1);
    ctl <= 8'h00;
    till(0, 1'b0);
    // reset again in mid-run with events pending
    rst <= 1'b1;
    cyc(8);
    cmp8(st, 8'h04);
    cmp1(int_n, 1'b1);
    rst <= 1'b0;
    cyc(8);
    cmp8(st & 8'h05, 8'h01);
    print_verdict();
  end
endmodule
